//--- ssq_params.svh
`ifndef SSQ_PARAMS_SVH
`define SSQ_PARAMS_SVH

// ---------------------------------------------------------------
// Register word indices (byte address = index * 4)
// ---------------------------------------------------------------
`define SSQ_IDX_CFG_WM 4'h0
`define SSQ_IDX_CFG_DEC 4'h1
`define SSQ_IDX_CFG_MODE 4'h2
`define SSQ_IDX_STAT_ONE 4'h3
`define SSQ_IDX_STAT_TWO 4'h4
`define SSQ_IDX_STAT_THREE 4'h5
`define SSQ_IDX_STAT_FOUR 4'h6
`define SSQ_IDX_DATA_LO 4'h7
`define SSQ_IDX_DATA_HI 4'h8

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define SSQ_WM_HALT_BIT 12
`define SSQ_DEC_ACCEL_LSB 3
`define SSQ_DEC_THIRD_LSB 6
`define SSQ_MODE_RATE_LSB 3
`define SSQ_ST2_EMPTY_BIT 4
`define SSQ_ST2_FULL_BIT 5
`define SSQ_ST2_WM_BIT 7

// ---------------------------------------------------------------
// Reset values and sizes
// ---------------------------------------------------------------
`define SSQ_RST_WM 12'h000
`define SSQ_RST_DEC 3'h0
`define SSQ_RST_MODE 3'h0
`define SSQ_RST_RATE 4'h0
`define SSQ_CAPACITY 12'hfff
`define SSQ_DEC_NONE 3'h1
`define SSQ_DEC_HALF 3'h2
`define SSQ_DEC_QUARTER 3'h4
`define SSQ_RATE_104HZ 4'h4
`define SSQ_RATE_208HZ 4'h5

`endif

//--- ssq_pkg.sv
package ssq_pkg;

    // Queue operating modes; other codes act as bypass
    typedef enum logic [2:0] {
        SSQ_BYPASS = 3'b000,
        SSQ_QUEUE = 3'b001,
        SSQ_CONT_TO_Q = 3'b011,
        SSQ_BYP_TO_CONT = 3'b100,
        SSQ_CONT = 3'b110
    } ssq_mode_type;

    // One three-axis sample set
    typedef struct packed {
        logic [15:0] z;
        logic [15:0] y;
        logic [15:0] x;
    } ssq_axes_type;

    // Index 0 rotation, 1 accel, 2 third set
    typedef ssq_axes_type [2:0] ssq_sets_type;

    // Avalon-MM request from the master
    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } ssq_av_req_type;

    // Avalon-MM answer to the master
    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } ssq_av_rsp_type;

endpackage

//--- ssq_readout.sv
// Design decisions made here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "ssq_params.svh"
// Functional notes
// [R1] Non-bypass modes: output register reads return the oldest stored word.
// [R2] Output read hands word to bus, shifts queue, loads next oldest.
// [R3] Unread-word count, 12 bits, split over status one and two.
// [R4] 10-bit pattern index in status three and four names next word.
// [R5] Low data register gives low byte, high register gives high byte.
// [R6] Empty flag once all read; reads while empty return last word.
// [R7] Host times status reads to data-ready or watermark interrupt.
// [R8] Host drains all words within one output-data-rate period.
// [R9] Paired output reads round back so repeated bursts keep popping.
// [R10] Words stored untagged; pattern index alone identifies them.
// [R11] Pattern index counts to last word of pattern, then wraps.
// [R12] First group holds all enabled sets; later only sets now due.
// [R13] Decimation codes: 001 none, 010 every second, 100 every fourth.
// [R14] Trigger-rate code 0100 is 104 Hz, 0101 is 208 Hz.
// [R15] Rotation undecimated, accel halved: nine-word pattern, 0 to 8.
// [R16] Rotation halved, accel full, third quartered: 21-word pattern.
// [R17] Watermark level counts 16-bit words, range 0 to 4095.
// [R18] Watermark flag when count after next write reaches the level.
// [R19] Host uses watermark in continuous modes, full flag otherwise.
// [R20] Halt bit set: storing stops at the watermark level.
// [R21] Halt bit clear: storing continues past level until full.
// [R22] Host keeps configuration unchanged while words remain stored.
// [R23] Mode code 011 continuous-to-queue, 100 bypass-to-continuous.
// [R24] Count up per write, down per read, never above capacity.
module ssq_readout (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_B,
    // Register bus
    input wire ssq_pkg::ssq_av_req_type I_AV,
    output ssq_pkg::ssq_av_rsp_type O_AV,
    // Sample source
    input wire logic I_TRIG,
    input wire logic I_EVENT,
    input wire ssq_pkg::ssq_sets_type I_SETS,
    // Status for the host interrupt logic
    output logic O_EMPTY,
    output logic O_FULL,
    output logic O_WATERMARK,
    output logic [3:0] O_RATE_CODE
);
    import ssq_pkg::*;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Decimation code to keep-every factor, 0 when the set is off
    function automatic logic [2:0] dec_factor(input logic [2:0] c);
        unique case (c)
            `SSQ_DEC_NONE: dec_factor = 3'h1; // R13
            `SSQ_DEC_HALF: dec_factor = 3'h2;
            `SSQ_DEC_QUARTER: dec_factor = 3'h4;
            default: dec_factor = 3'h0;
        endcase
    endfunction

    // Set is due at this trigger phase
    function automatic logic set_due(input logic [2:0] c,
                                     input logic [1:0] ph);
        logic [2:0] f;
        f = dec_factor(c);
        set_due = (f != 3'h0) && ((ph & 2'(f - 3'h1)) == 2'h0); // R12
    endfunction

    // Phase period: largest factor among enabled sets
    function automatic logic [2:0] period(input logic [8:0] d);
        logic [2:0] p;
        p = 3'h1;
        for (int s = 0; s < 3; s++) begin
            if (dec_factor(d[3*s +: 3]) > p) begin
                p = dec_factor(d[3*s +: 3]);
            end
        end
        period = p;
    endfunction

    // Words in one whole pattern repeat
    function automatic logic [9:0] pat_len(input logic [8:0] d);
        logic [9:0] n;
        n = 10'h000;
        for (int t = 0; t < 4; t++) begin
            for (int s = 0; s < 3; s++) begin
                if (3'(t) < period(d) && set_due(d[3*s +: 3], 2'(t))) begin
                    n = n + 10'h003; // R11
                end
            end
        end
        pat_len = n;
    endfunction

    // Merge written bytes into a register
    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = wd[8*b +: 8];
            end
        end
        be_merge = r;
    endfunction

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        logic wait_r;
        logic [31:0] rdata;
        logic popq;
        logic [12:0] wm_cfg;
        logic [8:0] dec;
        logic [2:0] mode;
        logic [3:0] rate;
        logic [11:0] count;
        logic [11:0] rd_ptr;
        logic [11:0] wr_ptr;
        logic [9:0] pattern;
        logic [1:0] phase;
        logic [8:0][15:0] stage;
        logic [3:0] stage_n;
        logic [3:0] stage_i;
        logic [15:0] last_word;
        logic empty;
        logic full;
        logic wm_hit;
    } ssq_state_type;

    ssq_state_type st_r;
    ssq_state_type st_nxt;
    logic [15:0] mem [0:4095];
    logic [15:0] head;
    logic mem_we;
    logic [11:0] mem_wa;
    logic [15:0] mem_wd;
    logic run;
    logic ovw;
    logic pop;
    logic drop;
    logic wr_en;
    logic have;
    logic acc;
    logic [11:0] limit;

    // Oldest word is always on the read port; no tag bits stored
    assign head = mem[st_r.rd_ptr]; // R10

    // ---------------------------------------------------------------
    // Next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        logic req;
        logic [3:0] idx;
        logic [3:0] n;
        logic [2:0] per;
        req = I_AV.read | I_AV.write;
        idx = I_AV.address[5:2];
        n = 4'h0;
        per = period(st_r.dec);
        st_nxt = st_r;
        acc = req && !st_r.wait_r;
        // One wait state on every access, then the answer
        st_nxt.wait_r = !(req && st_r.wait_r);

        // Mode decode; the event level steers the switching modes
        unique case (ssq_mode_type'(st_r.mode))
            SSQ_QUEUE: begin
                run = 1'b1;
                ovw = 1'b0;
            end
            SSQ_CONT: begin
                run = 1'b1;
                ovw = 1'b1;
            end
            SSQ_CONT_TO_Q: begin
                run = 1'b1; // R23
                ovw = !I_EVENT;
            end
            SSQ_BYP_TO_CONT: begin
                run = I_EVENT; // R23
                ovw = 1'b1;
            end
            default: begin
                run = 1'b0;
                ovw = 1'b0;
            end
        endcase
        // Halting at the level forbids overwriting the oldest word
        ovw = ovw && !st_r.wm_cfg[`SSQ_WM_HALT_BIT]; // R20
        limit = st_r.wm_cfg[`SSQ_WM_HALT_BIT] ? st_r.wm_cfg[11:0]
                                               : `SSQ_CAPACITY; // R21

        // Read capture at the first cycle of a read
        if (req && st_r.wait_r && I_AV.read) begin
            st_nxt.rdata = 32'h0000_0000;
            st_nxt.popq = 1'b0;
            unique case (idx)
                `SSQ_IDX_CFG_WM: st_nxt.rdata[12:0] = st_r.wm_cfg;
                `SSQ_IDX_CFG_DEC: st_nxt.rdata[8:0] = st_r.dec;
                `SSQ_IDX_CFG_MODE:
                    st_nxt.rdata[6:0] = {st_r.rate, st_r.mode};
                `SSQ_IDX_STAT_ONE:
                    st_nxt.rdata[7:0] = st_r.count[7:0]; // R3
                `SSQ_IDX_STAT_TWO: begin
                    st_nxt.rdata[3:0] = st_r.count[11:8]; // R3
                    st_nxt.rdata[`SSQ_ST2_EMPTY_BIT] = st_r.empty;
                    st_nxt.rdata[`SSQ_ST2_FULL_BIT] = st_r.full;
                    st_nxt.rdata[`SSQ_ST2_WM_BIT] = st_r.wm_hit;
                end
                `SSQ_IDX_STAT_THREE:
                    st_nxt.rdata[7:0] = st_r.pattern[7:0]; // R4
                `SSQ_IDX_STAT_FOUR:
                    st_nxt.rdata[1:0] = st_r.pattern[9:8]; // R4
                `SSQ_IDX_DATA_LO: st_nxt.rdata[7:0] = (st_r.count != 0)
                    ? head[7:0] : st_r.last_word[7:0]; // R5
                `SSQ_IDX_DATA_HI: begin
                    // Empty queue keeps handing out the last word
                    st_nxt.rdata[7:0] = (st_r.count != 0)
                        ? head[15:8] : st_r.last_word[15:8]; // R5 R6
                    st_nxt.popq = (st_r.count != 0); // R1
                end
                default: st_nxt.rdata = 32'h0000_0000;
            endcase
        end

        // Register writes take effect at the accepting edge
        if (acc && I_AV.write) begin
            unique case (idx)
                `SSQ_IDX_CFG_WM: st_nxt.wm_cfg = 13'(be_merge(
                    32'(st_r.wm_cfg), I_AV.writedata, I_AV.byteenable));
                `SSQ_IDX_CFG_DEC: st_nxt.dec = 9'(be_merge(
                    32'(st_r.dec), I_AV.writedata, I_AV.byteenable));
                `SSQ_IDX_CFG_MODE: {st_nxt.rate, st_nxt.mode} = 7'(be_merge(
                    32'({st_r.rate, st_r.mode}), I_AV.writedata,
                    I_AV.byteenable)); // R14
                default: st_nxt.rate = st_r.rate;
            endcase
        end

        // Reading the high half releases the word; the low half stays
        // readable, so lo/hi pairs round back onto the next word
        pop = acc && I_AV.read && idx == `SSQ_IDX_DATA_HI
              && st_r.popq; // R2 R9
        have = st_r.stage_i < st_r.stage_n;
        wr_en = run && have && (st_r.count < limit || pop || ovw);
        drop = wr_en && !(st_r.count < limit) && !pop;
        mem_we = wr_en;
        mem_wa = st_r.wr_ptr;
        mem_wd = st_r.stage[st_r.stage_i];

        // Queue pointers and count
        if (run && have) begin
            st_nxt.stage_i = st_r.stage_i + 4'h1; // full in stop mode: lost
        end
        if (wr_en) begin
            st_nxt.wr_ptr = st_r.wr_ptr + 12'h001;
        end
        if (pop || drop) begin
            st_nxt.rd_ptr = st_r.rd_ptr + 12'h001; // R2
            st_nxt.pattern = (st_r.pattern + 10'h001 >= pat_len(st_r.dec))
                ? 10'h000 : st_r.pattern + 10'h001; // R11 R15 R16
        end
        if (pop) begin
            st_nxt.last_word = head; // R6
        end
        st_nxt.count = st_r.count + 12'(wr_en) - 12'(pop)
                       - 12'(drop); // R24

        // Trigger loads one group of due sets into the stage
        if (run && I_TRIG && !have) begin
            for (int s = 0; s < 3; s++) begin
                if (set_due(st_r.dec[3*s +: 3], st_r.phase)) begin // R12
                    st_nxt.stage[n] = I_SETS[s].x;
                    st_nxt.stage[n + 4'h1] = I_SETS[s].y;
                    st_nxt.stage[n + 4'h2] = I_SETS[s].z;
                    n = n + 4'h3;
                end
            end
            st_nxt.stage_n = n;
            st_nxt.stage_i = 4'h0;
            st_nxt.phase = st_r.phase + 2'h1 & 2'(per - 3'h1);
        end

        // Bypass empties the queue and restarts the pattern
        if (!run) begin
            st_nxt.count = 12'h000;
            st_nxt.rd_ptr = 12'h000;
            st_nxt.wr_ptr = 12'h000;
            st_nxt.pattern = 10'h000;
            st_nxt.phase = 2'h0;
            st_nxt.stage_n = 4'h0;
            st_nxt.stage_i = 4'h0;
        end

        // Flags follow the new count
        st_nxt.empty = st_nxt.count == 12'h000; // R6
        st_nxt.full = st_nxt.count >= limit;
        st_nxt.wm_hit = 13'(st_nxt.count) + 13'h0001
                        >= 13'(st_r.wm_cfg[11:0]); // R17 R18
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    // Whole state in one register
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            st_r <= '0;
            st_r.wait_r <= 1'b1;
            st_r.wm_cfg <= {1'b0, `SSQ_RST_WM};
            st_r.dec <= {3{`SSQ_RST_DEC}};
            st_r.mode <= `SSQ_RST_MODE;
            st_r.rate <= `SSQ_RST_RATE;
            st_r.empty <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Sample storage, no reset
    always_ff @(posedge I_CLK) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // Outputs straight from the state register
    assign O_AV.readdata = st_r.rdata;
    assign O_AV.waitrequest = st_r.wait_r;
    assign O_EMPTY = st_r.empty;
    assign O_FULL = st_r.full;
    assign O_WATERMARK = st_r.wm_hit;
    assign O_RATE_CODE = st_r.rate; // R14

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    sequence s_hi_read;
        I_AV.read && I_AV.address[5:2] == `SSQ_IDX_DATA_HI && st_r.wait_r;
    endsequence
    sequence s_hi_accept;
        I_AV.read && !st_r.wait_r;
    endsequence

    a_count_cap: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        st_r.count <= `SSQ_CAPACITY) // R24
        else $error("count above capacity");
    a_count_step: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        run |=> (st_r.count - $past(st_r.count) <= 12'h001)
            || ($past(st_r.count) - st_r.count <= 12'h001)) // R24
        else $error("count moved by more than one");
    a_empty_last: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        s_hi_read ##0 (st_r.count == 12'h000) ##1 s_hi_accept
        |-> st_r.rdata[7:0] == st_r.last_word[15:8]) // R6
        else $error("empty read not last word");
    a_pop_advance: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        s_hi_read ##0 (st_r.count != 12'h000) ##1 s_hi_accept
        |=> st_r.rd_ptr == $past(st_r.rd_ptr) + 12'h001) // R2
        else $error("read did not advance queue");
    a_halt_stop: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        st_r.wm_cfg[`SSQ_WM_HALT_BIT] && st_r.count >= st_r.wm_cfg[11:0]
        |=> st_r.count <= $past(st_r.count)) // R20
        else $error("stored past watermark level");
    a_wm_flag: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        $rose(st_r.wm_hit) |-> 13'(st_r.count) + 13'h0001
            >= 13'($past(st_r.wm_cfg[11:0]))) // R18
        else $error("watermark flag early");
    a_pattern_wrap: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        run && pat_len(st_r.dec) != 10'h000 && $stable(st_r.dec)
        |-> st_r.pattern < pat_len(st_r.dec)) // R11
        else $error("pattern index past pattern end");
    a_bypass_flush: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        !run |=> st_r.count == 12'h000 && st_r.pattern == 10'h000) // R1
        else $error("bypass left words stored");
    a_bus_answer: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        (I_AV.read || I_AV.write) && st_r.wait_r |=> !st_r.wait_r)
        else $error("bus answer not after one wait");
    a_first_group: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        run && I_TRIG && !have && st_r.phase == 2'h0
        |=> st_r.stage_n == 4'(3 * ((dec_factor(st_r.dec[2:0]) != 0)
            + (dec_factor(st_r.dec[5:3]) != 0)
            + (dec_factor(st_r.dec[8:6]) != 0)))) // R12
        else $error("first group misses a set");

endmodule // ssq_readout

//--- ssq_sample_src.sv
`timescale 1ns/1ps
// ----------------------------------------------------------
// Sample source model feeding the queue
// ----------------------------------------------------------
module ssq_sample_src (
    // Clock
    input wire logic I_CLK,
    // Samples to the queue
    output logic o_trig,
    output ssq_pkg::ssq_sets_type o_sets
);
    import ssq_pkg::*;

    // Idle values before the first group
    initial begin
        o_trig = 1'b0;
        o_sets = '1;
    end

    // Word code: group, set, axis, so every word differs
    function automatic logic [15:0] w(input logic [3:0] g, input int s,
                                      input int a);
        return {g, 4'(s), 4'h5, 4'(a)};
    endfunction

    // One group per call; the long gap keeps triggers well apart
    task automatic send(input logic [3:0] g);
        @(posedge I_CLK);
        o_trig <= 1'b1;
        for (int s = 0; s < 3; s++) begin
            o_sets[s] <= {w(g, s, 2), w(g, s, 1), w(g, s, 0)};
        end
        @(posedge I_CLK);
        o_trig <= 1'b0;
        o_sets <= ~o_sets; // Not valid now, so no stale copy
        repeat (12) @(posedge I_CLK);
    endtask
endmodule // ssq_sample_src

//--- testbench.sv
`timescale 1ns/1ps
`include "ssq_params.svh"
// ----------------------------------------------------------
// Queue read-out bench
// ----------------------------------------------------------
module testbench;
    import ssq_pkg::*;
    logic I_CLK;
    logic I_RST_B;
    logic I_EVENT;
    ssq_av_req_type av_req;
    ssq_av_rsp_type av_rsp;
    logic trig;
    ssq_sets_type sets;
    logic empty;
    logic full;
    logic wm;
    logic [3:0] rate;
    logic [31:0] rd;
    int err_total = 0;
    int check_count = 0;

    ssq_readout DUT (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_AV(av_req),
        .O_AV(av_rsp), .I_TRIG(trig), .I_EVENT(I_EVENT), .I_SETS(sets),
        .O_EMPTY(empty), .O_FULL(full), .O_WATERMARK(wm),
        .O_RATE_CODE(rate));
    ssq_sample_src src (.I_CLK(I_CLK), .o_trig(trig), .o_sets(sets));

    // 250 MHz clock
    initial begin
        I_CLK = 1'b0;
        forever #2 I_CLK = ~I_CLK;
    end

    // ------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------
    task automatic test_done;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h not %h", $time, got, exp);
        end
    endtask

    // One Avalon cycle; held until waitrequest is seen low, however
    // long it takes: only the watchdog ends a hung wait
    task automatic av(input logic is_rd, input logic [3:0] idx,
                      input logic [31:0] wd, input logic [3:0] be = 4'hf);
        @(posedge I_CLK);
        av_req.read <= is_rd;
        av_req.write <= !is_rd;
        av_req.address <= {2'b00, idx, 2'b00};
        av_req.writedata <= wd;
        av_req.byteenable <= be;
        do begin
            @(posedge I_CLK);
        end while (av_rsp.waitrequest !== 1'b0);
        rd = av_rsp.readdata;
        av_req.read <= 1'b0;
        av_req.write <= 1'b0;
    endtask

    task automatic rdchk(input logic [3:0] idx, input logic [31:0] exp);
        av(1'b1, idx, 32'h0);
        chk(rd, exp);
    endtask

    // Bypass first, so no stored word meets a new setup
    task automatic cfg(input logic [31:0] wl, input logic [31:0] dec,
                       input logic [31:0] mode);
        av(1'b0, `SSQ_IDX_CFG_MODE, 32'h0);
        av(1'b0, `SSQ_IDX_CFG_WM, wl);
        av(1'b0, `SSQ_IDX_CFG_DEC, dec);
        av(1'b0, `SSQ_IDX_CFG_MODE, mode);
    endtask

    // Decimation factor equals its code; 0 leaves the set out
    task automatic run_pat(input int f0, input int f1, input int f2,
                           input int groups, input logic [3:0] r);
        logic [15:0] q[$];
        int fs[3];
        int n;
        fs = '{f0, f1, f2};
        for (int g = 0; g < groups; g++) begin
            for (int s = 0; s < 3; s++) begin
                if (fs[s] != 0 && g % fs[s] == 0) begin
                    for (int a = 0; a < 3; a++) begin
                        q.push_back({4'(g), 4'(s), 4'h5, 4'(a)});
                    end
                end
            end
        end
        cfg(32'hfff, {23'h0, 3'(f2), 3'(f1), 3'(f0)}, {25'h0, r, 3'h6});
        rdchk(`SSQ_IDX_CFG_DEC, {23'h0, 3'(f2), 3'(f1), 3'(f0)});
        rdchk(`SSQ_IDX_CFG_MODE, {25'h0, r, 3'h6});
        // Rate output long settled here, not at the launching edge
        chk({28'h0, rate}, {28'h0, r});
        for (int g = 0; g < groups; g++) begin
            src.send(4'(g));
        end
        n = q.size();
        rdchk(`SSQ_IDX_STAT_ONE, 32'(n));
        rdchk(`SSQ_IDX_STAT_TWO, 32'h0);
        rdchk(`SSQ_IDX_STAT_FOUR, 32'h0);
        for (int i = 0; i < n; i++) begin
            rdchk(`SSQ_IDX_STAT_THREE, 32'(i));
            rdchk(`SSQ_IDX_DATA_LO, {24'h0, q[i][7:0]});
            rdchk(`SSQ_IDX_DATA_HI, {24'h0, q[i][15:8]});
        end
        rdchk(`SSQ_IDX_STAT_THREE, 32'h0);
        rdchk(`SSQ_IDX_STAT_TWO, 32'h10);
        chk({31'h0, empty}, 32'h1);
        rdchk(`SSQ_IDX_DATA_HI, {24'h0, q[n-1][15:8]});
    endtask

    // ------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------
    initial begin
        I_RST_B <= 1'b0;
        I_EVENT <= 1'b0;
        av_req <= '0;
        repeat (16) @(posedge I_CLK);
        chk({29'h0, empty, full, wm}, 32'h4);
        I_RST_B <= 1'b1;
        rdchk(`SSQ_IDX_STAT_TWO, 32'h90);
        rdchk(4'hf, 32'h0);
        // Byte lane one only: level high bits and halt bit
        av(1'b0, `SSQ_IDX_CFG_WM, 32'hffff_1fff, 4'h2);
        rdchk(`SSQ_IDX_CFG_WM, 32'h1f00);
        run_pat(1, 2, 0, 2, `SSQ_RATE_208HZ);
        run_pat(2, 1, 4, 4, `SSQ_RATE_104HZ);
        // Halt at level 5 with rotation only
        cfg(32'h1005, 32'h1, 32'h6);
        src.send(4'h0);
        chk({31'h0, wm}, 32'h0);
        src.send(4'h1);
        rdchk(`SSQ_IDX_STAT_ONE, 32'h5);
        chk({30'h0, full, wm}, 32'h3);
        // Same level, no halt: storing runs past it
        cfg(32'h5, 32'h1, 32'h6);
        src.send(4'h0);
        src.send(4'h1);
        rdchk(`SSQ_IDX_STAT_ONE, 32'h6);
        chk({30'h0, full, wm}, 32'h1);
        // Event-driven modes
        cfg(32'hfff, 32'h1, 32'h4);
        src.send(4'h0);
        rdchk(`SSQ_IDX_STAT_ONE, 32'h0);
        I_EVENT <= 1'b1;
        src.send(4'h1);
        rdchk(`SSQ_IDX_STAT_ONE, 32'h3);
        I_EVENT <= 1'b0;
        cfg(32'hfff, 32'h1, 32'h3);
        src.send(4'h0);
        rdchk(`SSQ_IDX_STAT_ONE, 32'h3);
        test_done;
    end

    // Watchdog far beyond the expected run length
    initial begin
        repeat (20000) @(posedge I_CLK);
        err_total++;
        $display("wrong value at %0t: watchdog", $time);
        test_done;
    end
endmodule // testbench
